// ==== axr_regs.svh ====
// Purpose: Shared sizing constants for the ordered bus master
// Assumes: Included by the package and design files by its bare name
// Notes: Definitions only, no logic
`ifndef AXR_REGS_SVH
`define AXR_REGS_SVH

// Identifier widths at the master port and behind the interconnect
`define AXR_ID_W 4
`define AXR_PORT_W 4
`define AXR_SLV_ID_W 8

// Address, data and burst length fields
`define AXR_ADDR_W 32
`define AXR_DATA_W 32
`define AXR_LEN_W 4

// Outstanding tracking and buffering
`define AXR_CNT_W 4
`define AXR_WQ_DEPTH 4
`define AXR_WQ_PTR_W 2
`define AXR_FIFO_DEPTH 16
`define AXR_IL_DEPTH 1

`endif

// ==== axr_pkg.sv ====
// Purpose: Types shared by the ordered bus master and its user
// Assumes: Constants come from axr_regs.svh
// Notes: Struct widths follow the header macros
`default_nettype none
`include "axr_regs.svh"

package axr_pkg;

  // User command: one burst read or write
  typedef struct packed {
    logic write;
    logic order;
    logic [`AXR_ID_W-1:0] id;
    logic [`AXR_ADDR_W-1:0] addr;
    logic [`AXR_LEN_W-1:0] len;
  } axr_cmd_s;

  // Read beat handed back to the user
  typedef struct packed {
    logic [`AXR_ID_W-1:0] id;
    logic [`AXR_DATA_W-1:0] data;
    logic last;
  } axr_rbeat_s;

  // Issue sequencer states
  typedef enum logic [1:0] {
    AXR_ST_IDLE = 2'b00,
    AXR_ST_ADDR = 2'b01,
    AXR_ST_FENCE = 2'b10
  } axr_state_e;

endpackage

`default_nettype wire

// ==== axr_fifo.sv ====
// Purpose: Write data buffer between user and write data channel
// Assumes: One clock, synchronous active-high reset
// Notes: Read data come from a register; holds DEPTH words plus one staged
`default_nettype none

module axr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp;
  logic [PW-1:0] rp;
  logic [PW:0] cnt;
  wire push;
  wire load;

  // Stage a word whenever the output register is free or being taken
  assign in_ready = (cnt != (PW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign load = (cnt != '0) && (!out_valid || out_ready);

  // Storage array, no reset needed
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (load) begin
        rp <= rp + 1'b1;
      end
      cnt <= cnt + (PW+1)'(push) - (PW+1)'(load);
    end
  end

  // Registered output word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (load) begin
      out_valid <= 1'b1;
      out_data <= mem[rp];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== axr_master.sv ====
// Purpose: Bus master issuing ID-tagged reads and writes in a legal order
// Assumes: Shared bus clock with the interconnect; IDs arrive already stripped
// Notes: Writes are never interleaved; fence commands wait for completion
`default_nettype none
`include "axr_regs.svh"

module axr_master
  import axr_pkg::*;
#(
  parameter bit SINGLE_ID = 1'b0,
  parameter int FIFO_DEPTH = `AXR_FIFO_DEPTH,
  parameter int IL_DEPTH = `AXR_IL_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // User command
  input wire logic cmd_valid,
  input wire axr_pkg::axr_cmd_s cmd,
  output logic cmd_ready,
  // User write data
  input wire logic wd_valid,
  input wire logic [`AXR_DATA_W-1:0] wd_data,
  output logic wd_ready,
  // User read and write returns
  output logic rd_valid,
  output axr_pkg::axr_rbeat_s rd_beat,
  output logic wr_done_valid,
  output logic [`AXR_ID_W-1:0] wr_done_id,
  output logic id_err,
  output logic busy,
  // Write address channel
  output logic awvalid,
  input wire logic awready,
  output logic [`AXR_ID_W-1:0] awid,
  output logic [`AXR_ADDR_W-1:0] awaddr,
  output logic [`AXR_LEN_W-1:0] awlen,
  // Write data channel
  output logic wvalid,
  input wire logic wready,
  output logic [`AXR_ID_W-1:0] wid,
  output logic [`AXR_DATA_W-1:0] wdata,
  output logic wlast,
  // Write response channel
  input wire logic bvalid,
  output logic bready,
  input wire logic [`AXR_ID_W-1:0] bid,
  // Read address channel
  output logic arvalid,
  input wire logic arready,
  output logic [`AXR_ID_W-1:0] arid,
  output logic [`AXR_ADDR_W-1:0] araddr,
  output logic [`AXR_LEN_W-1:0] arlen,
  // Read data channel
  input wire logic rvalid,
  output logic rready,
  input wire logic [`AXR_ID_W-1:0] rid,
  input wire logic [`AXR_DATA_W-1:0] rdata,
  input wire logic rlast
);

  import axr_pkg::*;

  localparam int NID = 1 << `AXR_ID_W;
  localparam logic [`AXR_CNT_W-1:0] CNT_MAX = '1;
  localparam logic [`AXR_WQ_PTR_W:0] WQ_FULL = (`AXR_WQ_PTR_W+1)'(`AXR_WQ_DEPTH);

  axr_state_e state;
  axr_state_e next_state;
  logic [`AXR_CNT_W-1:0] rd_total;
  logic [`AXR_CNT_W-1:0] wr_total;
  logic [`AXR_ID_W-1:0] wq_id [`AXR_WQ_DEPTH];
  logic [`AXR_LEN_W-1:0] wq_len [`AXR_WQ_DEPTH];
  logic [`AXR_WQ_PTR_W-1:0] wq_wp;
  logic [`AXR_WQ_PTR_W-1:0] wq_rp;
  logic [`AXR_WQ_PTR_W:0] wq_cnt;
  logic [`AXR_LEN_W-1:0] beat;
  logic [NID-1:0] rd_zero;
  logic [NID-1:0] wr_zero;
  logic f_valid;
  logic [`AXR_DATA_W-1:0] f_data;
  logic [`AXR_ID_W-1:0] cmd_id;

  // Decoded handshakes and conditions
  wire aw_fire = awvalid && awready;
  wire ar_fire = arvalid && arready;
  wire w_fire = wvalid && wready;
  wire b_fire = bvalid && bready;
  wire r_fire = rvalid && rready;
  wire r_done = r_fire && rlast;
  wire wq_full = (wq_cnt == WQ_FULL);
  wire wq_empty = (wq_cnt == '0);
  wire tot_full = (rd_total == CNT_MAX) || (wr_total == CNT_MAX);
  wire fence_hold = cmd.order && busy;
  wire take = cmd_valid && cmd_ready;
  wire wq_push = take && cmd.write;
  wire wq_pop = w_fire && wlast;
  wire single_stream = SINGLE_ID || (IL_DEPTH <= 1);

  // Idle returns are always accepted; any ID order is legal
  assign rready = 1'b1;
  assign bready = 1'b1;
  assign busy = (rd_total != '0) || (wr_total != '0);
  assign cmd_id = SINGLE_ID ? '0 : cmd.id;
  // A fenced command is held until all earlier work has completed
  assign cmd_ready = (state == AXR_ST_IDLE) && !fence_hold && !(cmd.write && wq_full) && !tot_full;

  // Write data leaves strictly in address order, one burst at a time
  assign wvalid = !wq_empty && f_valid && single_stream;
  assign wid = wq_id[wq_rp];
  assign wdata = f_data;
  assign wlast = (beat == wq_len[wq_rp]);

  // Write data buffer; its ready stalls the user's data source
  axr_fifo #(
    .WIDTH(`AXR_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(wd_valid),
    .in_data(wd_data),
    .in_ready(wd_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(w_fire)
  );

  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      AXR_ST_IDLE: begin
        if (take) begin
          next_state = AXR_ST_ADDR;
        end else if (cmd_valid && fence_hold) begin
          next_state = AXR_ST_FENCE;
        end
      end
      AXR_ST_ADDR: begin
        if (aw_fire || ar_fire) begin
          next_state = AXR_ST_IDLE;
        end
      end
      AXR_ST_FENCE: begin
        if (!busy) begin
          next_state = AXR_ST_IDLE;
        end
      end
      default: begin
        next_state = AXR_ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= AXR_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Write address channel, held stable until taken; tags leave at master width
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      awvalid <= 1'b0;
      awid <= '0;
      awaddr <= '0;
      awlen <= '0;
    end else if (wq_push) begin
      awvalid <= 1'b1;
      awid <= cmd_id;
      awaddr <= cmd.addr;
      awlen <= cmd.len;
    end else if (awready) begin
      awvalid <= 1'b0;
    end
  end

  // Read address channel, held stable until taken
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      arvalid <= 1'b0;
      arid <= '0;
      araddr <= '0;
      arlen <= '0;
    end else if (take && !cmd.write) begin
      arvalid <= 1'b1;
      arid <= cmd_id;
      araddr <= cmd.addr;
      arlen <= cmd.len;
    end else if (arready) begin
      arvalid <= 1'b0;
    end
  end

  // Queue of issued writes; pushed with the address so data order matches
  always_ff @(posedge mclk) begin
    if (wq_push) begin
      wq_id[wq_wp] <= cmd_id;
      wq_len[wq_wp] <= cmd.len;
    end
  end

  // Queue pointers; head moves only after a whole burst, never mid-burst
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wq_wp <= '0;
      wq_rp <= '0;
      wq_cnt <= '0;
    end else begin
      if (wq_push) begin
        wq_wp <= wq_wp + 1'b1;
      end
      if (wq_pop) begin
        wq_rp <= wq_rp + 1'b1;
      end
      wq_cnt <= wq_cnt + (`AXR_WQ_PTR_W+1)'(wq_push) - (`AXR_WQ_PTR_W+1)'(wq_pop);
    end
  end

  // Beat within the head burst
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      beat <= '0;
    end else if (w_fire) begin
      beat <= wlast ? '0 : beat + 1'b1;
    end
  end

  // Outstanding totals; read ends on last beat, write only on response
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_total <= '0;
      wr_total <= '0;
    end else begin
      rd_total <= rd_total + `AXR_CNT_W'(ar_fire) - `AXR_CNT_W'(r_done);
      wr_total <= wr_total + `AXR_CNT_W'(aw_fire) - `AXR_CNT_W'(b_fire);
    end
  end

  // Per-ID outstanding counters; returns arrive stripped of port bits
  for (genvar g = 0; g < NID; g++) begin : g_id
    logic [`AXR_CNT_W-1:0] rcnt;
    logic [`AXR_CNT_W-1:0] wcnt;
    wire r_inc = ar_fire && (arid == `AXR_ID_W'(g));
    wire r_dec = r_done && (rid == `AXR_ID_W'(g));
    wire w_inc = aw_fire && (awid == `AXR_ID_W'(g));
    wire w_dec = b_fire && (bid == `AXR_ID_W'(g));
    assign rd_zero[g] = (rcnt == '0);
    assign wr_zero[g] = (wcnt == '0);
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        rcnt <= '0;
        wcnt <= '0;
      end else begin
        rcnt <= rcnt + `AXR_CNT_W'(r_inc) - `AXR_CNT_W'(r_dec);
        wcnt <= wcnt + `AXR_CNT_W'(w_inc) - `AXR_CNT_W'(w_dec);
      end
    end
  end

  // Returned IDs must match something outstanding; sticky until reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      id_err <= 1'b0;
    end else if ((r_fire && rd_zero[rid]) || (b_fire && wr_zero[bid])) begin
      id_err <= 1'b1;
    end
  end

  // Read beats passed on as they come; same-ID order relies on the far side
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
      rd_beat <= '0;
      wr_done_valid <= 1'b0;
      wr_done_id <= '0;
    end else begin
      rd_valid <= r_fire;
      if (r_fire) begin
        rd_beat <= '{id: rid, data: rdata, last: rlast};
      end
      wr_done_valid <= b_fire;
      if (b_fire) begin
        wr_done_id <= bid;
      end
    end
  end

  // Burst stays on one ID until its last beat
  AST_W_NO_INTERLEAVE: assert property (@(posedge mclk) disable iff (sys_rst)
    (w_fire && !wlast) |=> (!wq_empty && (wid == $past(wid)))) else $error("burst interleaved");

  // Stalled beat holds its tag and data
  AST_W_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    (wvalid && !wready) |=> (wvalid && $stable(wid) && $stable(wdata))) else $error("beat changed");

  // Beat tag is the oldest issued write address
  AST_W_ADDR_ORDER: assert property (@(posedge mclk) disable iff (sys_rst)
    (wq_push && wq_empty) |=> (!wq_empty && (wid == $past(cmd_id))))
    else $error("data not in address order");

  // Stalled address holds steady
  AST_AW_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    (awvalid && !awready) |=> (awvalid && $stable(awid) && $stable(awaddr) && $stable(awlen)))
    else $error("write address changed");

  // Fenced command only once nothing is outstanding
  AST_FENCE: assert property (@(posedge mclk) disable iff (sys_rst)
    (take && cmd.order) |-> (rd_total == '0) && (wr_total == '0)) else $error("fence broken");

  // Read count falls only on a last beat
  AST_RD_DONE: assert property (@(posedge mclk) disable iff (sys_rst)
    (!ar_fire && !r_done) |=> (rd_total == $past(rd_total))) else $error("read completed early");

  // Write count falls only on a response, not on the last beat
  AST_WR_DONE: assert property (@(posedge mclk) disable iff (sys_rst)
    (wq_pop && !b_fire && !aw_fire) |=> (wr_total == $past(wr_total))) else $error("write completed early");

  // Single-ID master drives zero tags
  AST_ZERO_ID: assert property (@(posedge mclk) disable iff (sys_rst)
    (SINGLE_ID && (awvalid || arvalid)) |-> (awid == '0) && (arid == '0)) else $error("tag not zero");

  // Beats only ever for a queued address
  AST_WID_QUEUED: assert property (@(posedge mclk) disable iff (sys_rst)
    wvalid |-> (!wq_empty && (wq_cnt <= WQ_FULL))) else $error("beat without address");

endmodule

`default_nettype wire

// ==== axr_slv_model.sv ====
// Purpose: Slave and interconnect model facing the ordered master
// Assumes: bready and rready are held high by the master
// Notes: In order unless reorder is set, which is meant for distinct IDs only
`default_nettype none
`include "axr_regs.svh"

module axr_slv_model #(
  parameter logic [3:0] PORT = 4'hA
) (
  // Clock, reset, test controls
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic reorder,
  // Write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awid,
  input wire logic wvalid,
  output logic wready,
  input wire logic wlast,
  output logic bvalid,
  output logic [3:0] bid,
  // Read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] arid,
  input wire logic [31:0] araddr,
  input wire logic [3:0] arlen,
  output logic rvalid,
  output logic [3:0] rid,
  output logic [31:0] rdata,
  output logic rlast
);
  logic [7:0] awq[$];
  logic [7:0] bq[$];
  logic [43:0] arq[$];
  logic [43:0] cur;
  logic [3:0] beat;
  logic [3:0] tick;
  logic act;
  int wdone;

  // Fixed stall pattern when slow, never used to steer data order
  assign awready = !slow || tick[1];
  assign arready = !slow || tick[0];
  assign wready = !slow || tick[0];

  // Queues keep the wide slave-side IDs
  always @(posedge mclk) begin
    if (sys_rst) begin
      tick <= 4'h0;
      act <= 1'b0;
      beat <= 4'h0;
      bvalid <= 1'b0;
      bid <= 4'h0;
      rvalid <= 1'b0;
      rid <= 4'h0;
      rdata <= 32'h0;
      rlast <= 1'b0;
      wdone = 0;
      awq.delete();
      bq.delete();
      arq.delete();
    end else begin
      tick <= tick + 4'h1;
      if (awvalid && awready) awq.push_back({PORT, awid});
      if (arvalid && arready) arq.push_back({PORT, arid, araddr, arlen});
      if (wvalid && wready && wlast) wdone++;
      // Response needs both the address and its whole burst
      if (wdone > 0 && awq.size() > 0) begin
        bq.push_back(awq.pop_front());
        wdone--;
      end
      if (bvalid) begin
        bvalid <= 1'b0;
        bid <= ~bid;
      end else if (bq.size() > 0 && bq[0][7:4] == PORT) begin
        bvalid <= 1'b1;
        bid <= bq[0][3:0];
        void'(bq.pop_front());
      end
      // One burst at a time; reorder waits for two so it has a choice
      if (!act && arq.size() > (reorder ? 1 : 0)) begin
        cur = reorder ? arq.pop_back() : arq.pop_front();
        act <= 1'b1;
        beat <= 4'h0;
      end
      // Released lines toggle so stale data cannot look valid
      if (act && cur[43:40] == PORT) begin
        rvalid <= 1'b1;
        rid <= cur[39:36];
        rdata <= cur[35:4] + 32'(beat);
        rlast <= beat == cur[3:0];
        beat <= beat + 4'h1;
        act <= beat != cur[3:0];
      end else begin
        rvalid <= 1'b0;
        rid <= ~rid;
        rdata <= ~rdata;
        rlast <= ~rlast;
      end
    end
  end
endmodule

`default_nettype wire

// ==== axr_master_tb_top.sv ====
// Purpose: Self-checking bench for the ordered bus master
// Assumes: Slave model answers on the far side
// Notes: Inputs move on the falling edge
`default_nettype none
`include "axr_regs.svh"

module axr_master_tb_top
  import axr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0, wd_valid = 1'b0, slow = 1'b1, reorder = 1'b0;
  axr_cmd_s cmd = '0;
  logic [31:0] wd_data = 32'h0;
  logic cmd_ready, wd_ready, rd_valid, wr_done_valid, id_err, busy;
  axr_rbeat_s rd_beat;
  logic [3:0] wr_done_id, awid, wid, bid, arid, rid, awlen, arlen;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic awvalid, awready, wvalid, wready, wlast, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rlast;
  int fails = 0, n_tests = 0, cyc = 0, t_ar = -1, t_b = 0;
  logic [36:0] wq[$];
  axr_rbeat_s rq[$];
  logic [3:0] bq[$];
  logic [35:0] aq[$];

  always #5 mclk = ~mclk;

  axr_master DUT (
    .mclk, .sys_rst, .cmd_valid, .cmd, .cmd_ready, .wd_valid, .wd_data, .wd_ready,
    .rd_valid, .rd_beat, .wr_done_valid, .wr_done_id, .id_err, .busy,
    .awvalid, .awready, .awid, .awaddr, .awlen, .wvalid, .wready, .wid, .wdata, .wlast,
    .bvalid, .bready, .bid, .arvalid, .arready, .arid, .araddr, .arlen,
    .rvalid, .rready, .rid, .rdata, .rlast
  );
  axr_slv_model u_slv (
    .mclk, .sys_rst, .slow, .reorder, .awvalid, .awready, .awid, .wvalid, .wready, .wlast,
    .bvalid, .bid, .arvalid, .arready, .arid, .araddr, .arlen, .rvalid, .rid, .rdata, .rlast
  );

  // Record traffic; values read here are those before the edge
  always @(posedge mclk) begin
    cyc++;
    if (wvalid && wready) wq.push_back({wlast, wid, wdata});
    if (rd_valid) rq.push_back(rd_beat);
    if (wr_done_valid) bq.push_back(wr_done_id);
    if (wr_done_valid) t_b = cyc;
    if (arvalid && t_ar < 0) t_ar = cyc;
    if (awvalid && awready) aq.push_back({awlen, awaddr});
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [36:0] exp, input logic [36:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic hang(input string what);
    $display("wrong value %s expected ready seen timeout", what);
    fails++;
    finish_test();
  endtask

  // Valid is left high; idle drops it so no signal moves twice at one edge
  task automatic send(input logic w, input logic o, input logic [3:0] id, input logic [31:0] a,
                      input logic [3:0] n);
    int k;
    cmd = '{w, o, id, a, n};
    cmd_valid = 1'b1;
    #1;
    for (k = 0; k < 500 && cmd_ready !== 1'b1; k++) @(negedge mclk);
    if (k == 500) hang("cmd_ready");
    @(negedge mclk);
  endtask

  task automatic push(input logic [31:0] d);
    int k;
    wd_data = d;
    wd_valid = 1'b1;
    #1;
    for (k = 0; k < 500 && wd_ready !== 1'b1; k++) @(negedge mclk);
    if (k == 500) hang("wd_ready");
    @(negedge mclk);
  endtask

  task automatic idle();
    cmd_valid = 1'b0;
    wd_valid = 1'b0;
    @(negedge mclk);
  endtask

  task automatic settle(input int nr, input int nb);
    int k;
    for (k = 0; k < 2000 && !(rq.size() >= nr && bq.size() >= nb && busy === 1'b0); k++)
      @(negedge mclk);
    if (k == 2000) hang("completion");
  endtask

  // Fill the buffer with nothing queued, then drain it while the slave stalls
  task automatic s_fill();
    int k;
    wd_valid = 1'b1;
    for (k = 0; k < 40; k++) begin
      wd_data = 32'h1000 + k;
      #1;
      if (wd_ready !== 1'b1) break;
      @(negedge mclk);
    end
    wd_valid = 1'b0;
    chk("buffered words", `AXR_FIFO_DEPTH + 1, k);
    @(negedge mclk);
    send(1'b1, 1'b0, 4'h6, 32'h40, 4'hF);
    send(1'b1, 1'b0, 4'h6, 32'h80, 4'h0);
    idle();
    settle(0, 2);
    chk("aw", {4'hF, 32'h40}, aq[0]);
    chk("aw", {4'h0, 32'h80}, aq[1]);
    for (k = 0; k < 17; k++) chk("w beat", {k >= 15, 4'h6, 32'h1000 + k}, wq[k]);
    chk("b ids", {4'h6, 4'h6}, {bq[0], bq[1]});
    chk("wd_ready", 1'b1, wd_ready);
  endtask

  // Same and different IDs: data in address order, never interleaved
  task automatic s_worder();
    int k;
    logic [3:0] ids [4] = '{4'h3, 4'h3, 4'h5, 4'h3};
    slow = 1'b0;
    send(1'b1, 1'b0, 4'h3, 32'h100, 4'h1);
    send(1'b1, 1'b0, 4'h5, 32'h200, 4'h0);
    send(1'b1, 1'b0, 4'h3, 32'h300, 4'h0);
    idle();
    for (k = 0; k < 4; k++) push(32'h2000 + k);
    idle();
    settle(0, 3);
    for (k = 0; k < 4; k++) chk("w beat", {k > 0, ids[k], 32'h2000 + k}, wq[k]);
    chk("b ids", {4'h3, 4'h5, 4'h3}, {bq[0], bq[1], bq[2]});
  endtask

  // Two same-ID bursts come back whole and in issue order
  task automatic s_rsame();
    int k;
    send(1'b0, 1'b0, 4'h2, 32'h100, 4'h1);
    send(1'b0, 1'b0, 4'h2, 32'h200, 4'h2);
    idle();
    settle(5, 0);
    for (k = 0; k < 5; k++)
      chk("r beat", {4'h2, k < 2 ? 32'h100 + k : 32'h1FE + k, k == 1 || k == 4}, rq[k]);
  endtask

  // Different IDs returned newest first must be accepted
  task automatic s_rorder();
    int k;
    reorder = 1'b1;
    send(1'b0, 1'b0, 4'h1, 32'h300, 4'h0);
    send(1'b0, 1'b0, 4'h4, 32'h400, 4'h0);
    idle();
    for (k = 0; k < 200 && rq.size() < 1; k++) @(negedge mclk);
    reorder = 1'b0;
    settle(2, 0);
    chk("r beat newest", {4'h4, 32'h400, 1'b1}, rq[0]);
    chk("r beat oldest", {4'h1, 32'h300, 1'b1}, rq[1]);
  endtask

  // A fenced read waits for the write response, not for the data
  task automatic s_fence();
    slow = 1'b1;
    t_ar = -1;
    send(1'b1, 1'b0, 4'h7, 32'h500, 4'h0);
    cmd = '{1'b0, 1'b1, 4'h7, 32'h600, 4'h0};
    repeat (4) begin
      @(negedge mclk);
      chk("fence cmd_ready", 1'b0, cmd_ready);
    end
    push(32'h3000);
    idle();
    send(1'b0, 1'b1, 4'h7, 32'h600, 4'h0);
    idle();
    settle(1, 1);
    chk("read after response", 1'b1, t_ar > t_b);
    chk("fenced read", {4'h7, 32'h600, 1'b1}, rq[0]);
  endtask

  // Scenarios each start with empty records of what they check; aq is never cleared
  initial begin
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge mclk);
    s_fill();
    bq.delete();
    wq.delete();
    s_worder();
    bq.delete();
    s_rsame();
    rq.delete();
    s_rorder();
    rq.delete();
    s_fence();
    chk("id_err", 1'b0, id_err);
    chk("busy", 1'b0, busy);
    chk("return readies", 2'b11, {bready, rready});
    finish_test();
  end
endmodule

`default_nettype wire
